/* File: pss_defines.svh */
// constants of the summary status block: indices, bit positions, resets
`ifndef PSS_DEFINES_SVH
`define PSS_DEFINES_SVH
// register indices; byte address is four times the index
`define PSS_IDX_SUMMARY 8'h10
`define PSS_IDX_IRQ_STS 8'h11
`define PSS_IDX_IRQ_MSK 8'h12
`define PSS_IDX_RXERR_CNT 8'h15
`define PSS_IDX_FCAR_CNT 8'h14
`define PSS_IDX_NEG_EXP 8'h06
`define PSS_IDX_BASIC_STS 8'h01
// summary bit positions
`define PSS_B_RSVD15 15
`define PSS_B_XOVER 14
`define PSS_B_RXERR 13
`define PSS_B_POL 12
`define PSS_B_FCAR 11
`define PSS_B_SIGDET 10
`define PSS_B_LOCK 9
`define PSS_B_PAGE 8
`define PSS_B_RSVD7 7
`define PSS_B_RFAULT 6
`define PSS_B_JABBER 5
`define PSS_B_ANDONE 4
`define PSS_B_LOOP 3
`define PSS_B_DUPLEX 2
`define PSS_B_SPEED10 1
`define PSS_B_LINK 0
// interrupt event bit positions
`define PSS_I_RXERR 0
`define PSS_I_FCAR 1
`define PSS_I_RFAULT 2
`define PSS_I_SIGLOSS 3
`define PSS_I_LOCKLOSS 4
`define PSS_I_PAGE 5
`define PSS_I_W 6
// reset values
`define PSS_RST_BIT 1'b0
`define PSS_RST_IRQ 6'h00
`define PSS_RST_WORD 16'h0000
`define PSS_RST_DATA 32'h0000_0000
`endif

/* File: pss_pkg.sv */
// types shared by the summary status block
package pss_pkg;
   // live levels and one-cycle events from the rest of the transceiver
   typedef struct packed {
      logic xover_swapped; // automatic crossover currently swapped
      logic rx_err_ev; // receive error event pulse
      logic pol_inverted; // mirrored polarity flag of 10 Mb/s status
      logic fcar_ev; // false carrier event pulse
      logic sig_detect; // unconditional 100 Mb/s signal detect
      logic descr_lock; // 100 Mb/s descrambler lock
      logic page_rx; // mirrored page-received flag
      logic rfault_ev; // remote fault from negotiation, pulse
      logic jabber; // mirrored jabber detect flag
      logic an_done; // negotiation complete
      logic loopback; // loopback enabled
      logic full_duplex; // resolved duplex
      logic speed10; // resolved speed, 1 for 10 Mb/s
      logic link_ok; // mirrored link status
   } pss_src_t;
   // read strobes of the neighbouring source registers
   typedef struct packed {
      logic rxerr_cnt_rd; // receive error counter read
      logic fcar_cnt_rd; // false carrier counter read
      logic basic_sts_rd; // basic status register read
   } pss_rdclr_t;
   // crossover controls from the phy control register
   typedef struct packed {
      logic auto_enable; // crossover_auto_enable
      logic force_swap; // crossover_force
   } pss_xover_t;
endpackage

/* File: pss_status.sv */
// apb slave holding the phy_status_summary word and its interrupt logic
//
// Behaviour
// - summary word at index 0x10, live state
// - bit 15 reads zero, writes ignored
// - bit 14 crossover state per enable, force
// - bit 13 latches receive error, counter read clears
// - bit 12 mirrors polarity, own read keeps
// - bit 11 latches false carrier, counter read clears
// - bit 10 signal detect, latch low
// - bit 9 descrambler lock, latch low
// - bit 8 mirrors page received flag
// - bit 7 reads zero, writes ignored
// - bit 6 remote fault, basic read clears
// - bit 5 mirrors jabber, own read keeps
// - bit 4 negotiation complete
// - bit 3 loopback enabled
// - bits 2,1 duplex and speed
// - bit 0 mirrors link status
`timescale 1ns/1ps
`include "pss_defines.svh"
module pss_status
   import pss_pkg::*;
(
   input wire logic sys_clk_i, // 250 MHz clock
   input wire logic nrst_i, // synchronous reset, active low
   input wire logic psel_i, // apb select
   input wire logic penable_i, // apb access phase
   input wire logic pwrite_i, // apb direction
   input wire logic [31:0] paddr_i, // apb byte address
   input wire logic [31:0] pwdata_i, // apb write data
   output logic [31:0] prdata_o, // apb read data
   output logic pready_o, // apb ready
   output logic pslverr_o, // apb error for unmapped
   input wire pss_src_t src_i, // live state and events
   input wire pss_rdclr_t rdclr_i, // source register reads
   input wire pss_xover_t xover_i, // crossover controls
   output logic irq_o // level interrupt
);

   // word index of an apb byte address; low two bits dropped
   function automatic logic [7:0] word_idx(input logic [31:0] a);
      word_idx = a[9:2];
   endfunction

   // true when an address is one of the mapped words
   function automatic logic mapped(input logic [31:0] a);
      mapped = (a[31:10] == 22'h000000) && (a[1:0] == 2'b00) &&
         (word_idx(a) == `PSS_IDX_SUMMARY ||
          word_idx(a) == `PSS_IDX_IRQ_STS ||
          word_idx(a) == `PSS_IDX_IRQ_MSK);
   endfunction

   logic setup_c; // first cycle of a transfer
   logic done_c; // completing access edge
   logic wr_c; // write completes this edge
   logic rd_sum_c; // summary read completes this edge
   logic wr_sts_c; // write to irq status completes
   logic wr_msk_c; // write to irq mask completes
   logic [7:0] idx_c; // decoded word index
   logic rxerr_q; // receive error latch
   logic fcar_q; // false carrier latch
   logic rfault_q; // remote fault latch
   logic sigdet_q; // latch-low signal detect
   logic lock_q; // latch-low descrambler lock
   logic page_prev_q; // page flag last cycle, for edge
   logic xover_q; // registered crossover state
   logic [15:0] sum_c; // assembled summary word
   logic [`PSS_I_W-1:0] ev_c; // interrupt events this cycle
   logic [`PSS_I_W-1:0] ists_q; // sticky interrupt status
   logic [`PSS_I_W-1:0] imsk_q; // interrupt mask
   logic [31:0] prdata_q; // read data register
   logic pready_q; // ready register
   logic pslverr_q; // error register
   logic irq_q; // interrupt register

   // bus phase decode
   always_comb
   begin
      idx_c = word_idx(paddr_i);
      setup_c = psel_i && !penable_i;
      done_c = psel_i && penable_i && pready_q;
      wr_c = done_c && pwrite_i && mapped(paddr_i);
      rd_sum_c = done_c && !pwrite_i && mapped(paddr_i) &&
         (idx_c == `PSS_IDX_SUMMARY);
      // writes to the summary index fall through with no effect
      wr_sts_c = wr_c && (idx_c == `PSS_IDX_IRQ_STS);
      wr_msk_c = wr_c && (idx_c == `PSS_IDX_IRQ_MSK);
   end

   // crossover state: force wins, else automatic when enabled
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         xover_q <= `PSS_RST_BIT;
      else if (xover_i.force_swap)
         xover_q <= 1'b1;
      else if (xover_i.auto_enable)
         xover_q <= src_i.xover_swapped;
      else
         xover_q <= 1'b0;
   end

   // event latches: a new event wins over a clearing read
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         rxerr_q <= `PSS_RST_BIT;
         fcar_q <= `PSS_RST_BIT;
         rfault_q <= `PSS_RST_BIT;
      end
      else
      begin
         rxerr_q <= src_i.rx_err_ev ||
            (rxerr_q && !rdclr_i.rxerr_cnt_rd);
         fcar_q <= src_i.fcar_ev ||
            (fcar_q && !rdclr_i.fcar_cnt_rd);
         rfault_q <= src_i.rfault_ev ||
            (rfault_q && !rdclr_i.basic_sts_rd);
      end
   end

   // latch-low bits: a loss holds zero until the summary is read
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         sigdet_q <= `PSS_RST_BIT;
         lock_q <= `PSS_RST_BIT;
      end
      else
      begin
         // a current loss wins over the reload on read
         sigdet_q <= src_i.sig_detect && (sigdet_q || rd_sum_c);
         lock_q <= src_i.descr_lock && (lock_q || rd_sum_c);
      end
   end

   // assemble the summary word from latches and mirrors
   always_comb
   begin
      sum_c = `PSS_RST_WORD;
      sum_c[`PSS_B_RSVD15] = 1'b0;
      sum_c[`PSS_B_XOVER] = xover_q;
      sum_c[`PSS_B_RXERR] = rxerr_q;
      sum_c[`PSS_B_POL] = src_i.pol_inverted;
      sum_c[`PSS_B_FCAR] = fcar_q;
      sum_c[`PSS_B_SIGDET] = sigdet_q;
      sum_c[`PSS_B_LOCK] = lock_q;
      sum_c[`PSS_B_PAGE] = src_i.page_rx;
      sum_c[`PSS_B_RSVD7] = 1'b0;
      sum_c[`PSS_B_RFAULT] = rfault_q;
      sum_c[`PSS_B_JABBER] = src_i.jabber;
      sum_c[`PSS_B_ANDONE] = src_i.an_done;
      sum_c[`PSS_B_LOOP] = src_i.loopback;
      sum_c[`PSS_B_DUPLEX] = src_i.full_duplex;
      sum_c[`PSS_B_SPEED10] = src_i.speed10;
      sum_c[`PSS_B_LINK] = src_i.link_ok;
   end

   // page flag history, so only a new page raises an event
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         page_prev_q <= `PSS_RST_BIT;
      else
         page_prev_q <= src_i.page_rx;
   end

   // interrupt events of the block
   always_comb
   begin
      ev_c = `PSS_RST_IRQ;
      ev_c[`PSS_I_RXERR] = src_i.rx_err_ev;
      ev_c[`PSS_I_FCAR] = src_i.fcar_ev;
      ev_c[`PSS_I_RFAULT] = src_i.rfault_ev;
      ev_c[`PSS_I_SIGLOSS] = sigdet_q && !src_i.sig_detect;
      ev_c[`PSS_I_LOCKLOSS] = lock_q && !src_i.descr_lock;
      ev_c[`PSS_I_PAGE] = src_i.page_rx && !page_prev_q;
   end

   // sticky status, write one to clear; a new event wins
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         ists_q <= `PSS_RST_IRQ;
      else if (wr_sts_c)
         ists_q <= ev_c | (ists_q & ~pwdata_i[`PSS_I_W-1:0]);
      else
         ists_q <= ev_c | ists_q;
   end

   // interrupt mask, one enables the bit
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         imsk_q <= `PSS_RST_IRQ;
      else if (wr_msk_c)
         imsk_q <= pwdata_i[`PSS_I_W-1:0];
   end

   // interrupt output, one cycle after the status bit
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
         irq_q <= 1'b0;
      else
         irq_q <= |(ists_q & imsk_q);
   end

   // apb answer: data and ready are prepared in the setup cycle
   always_ff @(posedge sys_clk_i)
   begin
      if (!nrst_i)
      begin
         prdata_q <= `PSS_RST_DATA;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else if (setup_c)
      begin
         pready_q <= 1'b1;
         pslverr_q <= !mapped(paddr_i);
         if (pwrite_i || !mapped(paddr_i))
            prdata_q <= `PSS_RST_DATA; // unmapped reads return zero
         else if (idx_c == `PSS_IDX_SUMMARY)
            prdata_q <= {16'h0000, sum_c};
         else if (idx_c == `PSS_IDX_IRQ_STS)
            prdata_q <= {26'h0000000, ists_q};
         else
            prdata_q <= {26'h0000000, imsk_q};
      end
      else
      begin
         // ready drops after the access phase
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign irq_o = irq_q;

   // checks of the block's own behaviour
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (!nrst_i);

   property p_resv_zero;
      pready_o && !pslverr_o |-> !prdata_o[`PSS_B_RSVD15] &&
         !prdata_o[`PSS_B_RSVD7];
   endproperty
   a_resv_zero: assert property (p_resv_zero)
      else $error("reserved summary bit read as one");

   property p_force;
      xover_i.force_swap |=> sum_c[`PSS_B_XOVER];
   endproperty
   a_force: assert property (p_force)
      else $error("forced crossover not reported");

   property p_rxerr_hold;
      rxerr_q && !rdclr_i.rxerr_cnt_rd |=> rxerr_q;
   endproperty
   a_rxerr_hold: assert property (p_rxerr_hold)
      else $error("receive error latch lost without counter read");

   property p_rxerr_set;
      src_i.rx_err_ev |=> sum_c[`PSS_B_RXERR];
   endproperty
   a_rxerr_set: assert property (p_rxerr_set)
      else $error("receive error event not latched");

   property p_fcar;
      src_i.fcar_ev ##1 (!rdclr_i.fcar_cnt_rd)[*2] |=> fcar_q;
   endproperty
   a_fcar: assert property (p_fcar)
      else $error("false carrier latch cleared early");

   property p_siglow;
      !src_i.sig_detect |=> !sigdet_q ##1 (!sigdet_q || $past(rd_sum_c));
   endproperty
   a_siglow: assert property (p_siglow)
      else $error("signal detect loss not held");

   property p_lock_low;
      lock_q && !src_i.descr_lock |=> !sum_c[`PSS_B_LOCK];
   endproperty
   a_lock_low: assert property (p_lock_low)
      else $error("descrambler lock loss not latched");

   property p_rfault;
      src_i.rfault_ev |=> rfault_q;
   endproperty
   a_rfault: assert property (p_rfault)
      else $error("remote fault not latched");

   property p_wr_none;
      wr_c && idx_c == `PSS_IDX_SUMMARY |=> $stable(imsk_q);
   endproperty
   a_wr_none: assert property (p_wr_none)
      else $error("summary write changed state");

   property p_read_data;
      setup_c && !pwrite_i && mapped(paddr_i) &&
         idx_c == `PSS_IDX_SUMMARY |=>
         pready_o && prdata_o[15:0] == $past(sum_c);
   endproperty
   a_read_data: assert property (p_read_data)
      else $error("summary read data wrong");

   property p_irq;
      |(ists_q & imsk_q) |=> irq_o;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt not raised");

   // mirrored bits are read back as the source showed them at setup
   property p_mirror;
      setup_c && !pwrite_i && mapped(paddr_i) &&
         idx_c == `PSS_IDX_SUMMARY |=>
         prdata_o[`PSS_B_POL] == $past(src_i.pol_inverted) &&
         prdata_o[`PSS_B_PAGE] == $past(src_i.page_rx) &&
         prdata_o[`PSS_B_JABBER] == $past(src_i.jabber) &&
         prdata_o[`PSS_B_LINK] == $past(src_i.link_ok);
   endproperty
   a_mirror: assert property (p_mirror)
      else $error("mirrored summary bit wrong");

   // a counter read with no new event clears the receive error latch
   property p_rxerr_clr;
      rdclr_i.rxerr_cnt_rd && !src_i.rx_err_ev |=> !rxerr_q;
   endproperty
   a_rxerr_clr: assert property (p_rxerr_clr)
      else $error("receive error latch not cleared by counter read");

   // a basic status read with no new fault clears the fault latch
   property p_rfault_clr;
      rdclr_i.basic_sts_rd && !src_i.rfault_ev |=> !rfault_q;
   endproperty
   a_rfault_clr: assert property (p_rfault_clr)
      else $error("remote fault latch not cleared by status read");

   // every event lands in the sticky status, even against a clear
   property p_sts_set;
      |ev_c |=> ((ists_q & $past(ev_c)) == $past(ev_c));
   endproperty
   a_sts_set: assert property (p_sts_set)
      else $error("interrupt event not recorded");

   c_sum_read: cover property (rd_sum_c);
   c_irq: cover property (irq_o);
   c_lock_reload: cover property (!lock_q ##1 rd_sum_c ##1 lock_q);
   c_unmapped: cover property (pready_o && pslverr_o);
   c_xover_force: cover property (xover_i.force_swap ##1 xover_q);
endmodule

/* File: tb_pss_status.sv */
// self-checking testbench of the summary status block over apb
`timescale 1ns/1ps
module tb_pss_status;
   import pss_pkg::*;
   logic sys_clk_i = 1'b0; // 250 MHz clock
   logic nrst_i = 1'b0; // synchronous reset, active low
   logic psel = 1'b0; // apb select
   logic penable = 1'b0; // apb access phase
   logic pwrite = 1'b0; // apb direction
   logic [31:0] paddr = 32'h0000_0000; // apb byte address
   logic [31:0] pwdata = 32'h0000_0000; // apb write data
   logic [31:0] prdata_o; // read data seen
   logic pready_o; // ready seen
   logic pslverr_o; // error seen
   logic irq_o; // interrupt level seen
   pss_src_t src = '0; // live state and events
   pss_rdclr_t rdclr = '0; // source register read pulses
   pss_xover_t xover = '0; // crossover controls
   int miscompares = 0; // mismatches
   int n_compared = 0; // comparisons made
   int cyc = 0; // cycle count for the hang guard
   logic [31:0] rv; // last read word
   logic re; // last read error flag
   logic [3:0] xt [4] = '{4'b1101, 4'b1011, 4'b1000, 4'b0010}; // en,frc,sw,exp
   // summary bit of each latched event: receive error, false carrier, fault
   logic [31:0] evb [3] = '{32'h0000_2000, 32'h0000_0800, 32'h0000_0040};
   // half period of 2 ns
   always #2 sys_clk_i = ~sys_clk_i;
   pss_status u_pss_status (
      .sys_clk_i(sys_clk_i),
      .nrst_i(nrst_i),
      .psel_i(psel),
      .penable_i(penable),
      .pwrite_i(pwrite),
      .paddr_i(paddr),
      .pwdata_i(pwdata),
      .prdata_o(prdata_o),
      .pready_o(pready_o),
      .pslverr_o(pslverr_o),
      .src_i(src),
      .rdclr_i(rdclr),
      .xover_i(xover),
      .irq_o(irq_o)
   );
   // verdict and end of run
   task complete_run;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // compare one value and report a mismatch
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e)
      begin
         $display("BAD %s exp %h got %h", nm, e, g);
         miscompares++;
      end
   endtask
   // one apb transfer: setup, then access until pready is sampled high
   task apb(input logic w, input logic [31:0] a, input logic [31:0] d);
      int n;
      @(posedge sys_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk_i);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge sys_clk_i);
         n++;
      end
      while (pready_o !== 1'b1 && n < 20);
      chk("pready", 32'h1, {31'h0, pready_o});
      rv = prdata_o;
      re = pslverr_o;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // read a word and compare it
   task rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000);
      chk(nm, e, rv);
   endtask
   // pulse one event (0 rx error, 1 false carrier, 2 remote fault) or clear
   task pulse(input int k, input logic c);
      @(posedge sys_clk_i);
      if (c)
         rdclr <= 3'h1 << (2 - k);
      else
      begin
         src.rx_err_ev <= (k == 0);
         src.fcar_ev <= (k == 1);
         src.rfault_ev <= (k == 2);
      end
      @(posedge sys_clk_i);
      rdclr <= '0;
      src.rx_err_ev <= 1'b0;
      src.fcar_ev <= 1'b0;
      src.rfault_ev <= 1'b0;
   endtask
   // hang guard
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         miscompares++;
         complete_run;
      end
   end
   // main sequence
   initial
   begin
      repeat (4) @(posedge sys_clk_i);
      nrst_i <= 1'b1;
      rdc("sum_rst", 32'h40, 32'h0);
      chk("irq_rst", 32'h0, {31'h0, irq_o});
      // latch-low bits reload only on a summary read
      src.sig_detect <= 1'b1;
      src.descr_lock <= 1'b1;
      rdc("ll_before", 32'h40, 32'h0);
      rdc("ll_after", 32'h40, 32'h0600);
      @(posedge sys_clk_i);
      src.descr_lock <= 1'b0;
      @(posedge sys_clk_i);
      src.descr_lock <= 1'b1;
      rdc("lock_lost", 32'h40, 32'h0400);
      rdc("lock_back", 32'h40, 32'h0600);
      // mirrored and live levels
      src.pol_inverted <= 1'b1;
      src.page_rx <= 1'b1;
      src.jabber <= 1'b1;
      src.an_done <= 1'b1;
      src.loopback <= 1'b1;
      src.full_duplex <= 1'b1;
      src.speed10 <= 1'b1;
      src.link_ok <= 1'b1;
      rdc("mirror", 32'h40, 32'h173f);
      rdc("mirror_keep", 32'h40, 32'h173f);
      // writes to the summary word change nothing
      apb(1'b1, 32'h40, 32'hffff_ffff);
      chk("wr_err", 32'h0, {31'h0, re});
      rdc("after_wr", 32'h40, 32'h173f);
      // crossover table: force, enable with swap, enable, off
      for (int i = 0; i < 4; i++)
      begin
         xover.auto_enable <= xt[i][3];
         xover.force_swap <= xt[i][2];
         src.xover_swapped <= xt[i][1];
         apb(1'b0, 32'h40, 32'h0);
         chk("xover", {31'h0, xt[i][0]}, {31'h0, rv[14]});
      end
      // sticky events survive summary reads, cleared by their own read
      for (int k = 0; k < 3; k++)
      begin
         pulse(k, 1'b0);
         rdc("ev_set", 32'h40, 32'h173f | evb[k]);
         rdc("ev_keep", 32'h40, 32'h173f | evb[k]);
         if (k == 2)
            rdc("ev_keep6", 32'h40, 32'h177f);
         pulse(k, 1'b1);
         rdc("ev_clr", 32'h40, 32'h173f);
      end
      // interrupts: clear, unmask, raise, clear, masked event
      apb(1'b1, 32'h44, 32'h3f);
      rdc("irq_sts0", 32'h44, 32'h0);
      apb(1'b1, 32'h48, 32'h01);
      rdc("irq_msk", 32'h48, 32'h01);
      pulse(0, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk("irq_hi", 32'h1, {31'h0, irq_o});
      rdc("irq_sts1", 32'h44, 32'h01);
      apb(1'b1, 32'h44, 32'h01);
      repeat (3) @(posedge sys_clk_i);
      chk("irq_lo", 32'h0, {31'h0, irq_o});
      apb(1'b1, 32'h48, 32'h00);
      pulse(1, 1'b0);
      repeat (3) @(posedge sys_clk_i);
      chk("irq_mskd", 32'h0, {31'h0, irq_o});
      rdc("irq_sts2", 32'h44, 32'h02);
      // unmapped and misaligned addresses are refused
      rdc("unmapped", 32'h400, 32'h0);
      chk("err_unm", 32'h1, {31'h0, re});
      rdc("misalign", 32'h42, 32'h0);
      chk("err_mis", 32'h1, {31'h0, re});
      complete_run;
   end
endmodule
